// File: shared/fp_mac_pkg.sv
// constants, code word layout and enumerations of the float compute unit
package fp_mac_pkg;
	// =====================================================
	// widths
	localparam int W      = 32;
	localparam int NREG   = 32;
	localparam int AW     = 5;
	localparam int NTMP   = 3;
	localparam int CW     = 34;
	localparam int OBUF_N = 2;
	// =====================================================
	// code word field positions
	localparam int C_RA   = 0;
	localparam int C_RB   = 5;
	localparam int C_RC   = 10;
	localparam int C_RD   = 15;
	localparam int C_FN   = 20;
	localparam int C_IO   = 23;
	localparam int C_CN   = 25;
	localparam int C_ASRC = 27;
	localparam int C_WREG = 28;
	localparam int C_TSRC = 29;
	localparam int C_TDST = 31;
	localparam int C_CVT  = 33;
	// =====================================================
	// mode register bits
	localparam int MODE_W     = 2;
	localparam int M_DPUMP    = 0;
	localparam int M_RANGE    = 1;
	localparam logic [MODE_W-1:0] MODE_RST = 2'h2;
	// =====================================================
	// float format constants
	localparam logic [7:0]  EXP_BIAS  = 8'h7f;
	localparam logic [7:0]  EXP_MAX   = 8'hff;
	localparam logic [7:0]  RCP_K     = 8'hfd;
	localparam logic [9:0]  FIX_BASE  = 10'h096;
	localparam logic [9:0]  FIX_LIM   = 10'h09e;
	localparam logic [1:0]  TMP_NONE  = 2'h3;
	localparam logic [31:0] INT_MAXP  = 32'h7fffffff;
	localparam logic [31:0] INT_MAXN  = 32'h80000000;
	// =====================================================
	// operation, port transfer and condition codes
	typedef enum logic [2:0] {
		FN_NOP = 3'h0, FN_MUL = 3'h1, FN_ADD = 3'h2, FN_SUB = 3'h3,
		FN_MAC = 3'h4, FN_MSB = 3'h5, FN_CVT = 3'h6, FN_RCP = 3'h7
	} fn_t;
	typedef enum logic [1:0] {
		IO_NONE = 2'h0, IO_LOAD = 2'h1, IO_STORE = 2'h2, IO_RESULT = 2'h3
	} io_t;
	typedef enum logic [1:0] {
		CN_NONE = 2'h0, CN_ZERO = 2'h1, CN_NEG = 2'h2, CN_POS = 2'h3
	} cond_t;
endpackage : fp_mac_pkg

// File: src/fp_mac_pipeline_unit.sv
// three stage float multiply/accumulate unit with register file and data port
//
// Overview of operation
// RULE_01: each arithmetic operation takes three cycles; one new operation every cycle.
// RULE_02: up to three operations in flight, one per pipeline stage.
// RULE_03: stage one multiplies, stage two adds or subtracts, last stage rounds and delivers; code rounds inside fmul and fadd, last stage does not round.
// RULE_04: all arithmetic uses single precision float operands and results.
// RULE_05: last stage rounds and converts between float and two's complement integer; code conversions truncate instead.
// RULE_06: register file of thirty-two 32-bit registers for operands and results.
// RULE_07: per cycle two operand reads, one result write, one port transfer.
// RULE_08: data port is 32 bits wide and moves one word each cycle.
// RULE_09: port loads and stores registers and feeds or takes the pipeline directly.
// RULE_10: three temporary registers allow x = x +/- y*z issued in one cycle.
// RULE_11: lookup gives approximate reciprocal, refined by multiply/accumulate steps.
// RULE_12: full divide takes eighteen cycles; other operations interleave freely.
// RULE_13: a code word is latched every clock and steers the next three cycles; code latches only while pipe_ready is high.
// RULE_14: condition and exception flags appear when the result is written back.
// RULE_15: four five-bit register address fields, one for each file port.
// RULE_16: three-bit function field picks the operation; other fields pick routing.
// RULE_17: two-bit port transfer field governs the data port each cycle.
// RULE_18: mode register holds routing and port timing options that rarely change.
// RULE_19: port input sampled on rising edge, also falling edge in double pump mode; code loads only the falling sample in double pump mode.
// RULE_20: port drivers released under control of the port drive enable input.
// RULE_21: condition and exception outputs reported; cancel and stall inputs honoured.
// RULE_22: cancel low, one cycle after an instruction, voids all its effects.
// RULE_23: stall low, in the instruction's own cycle, voids that instruction.
// RULE_24: drive enable high releases the port drivers at once, without the clock.
// RULE_25: zero output flags an exactly zero result, gated by the condition field.
`timescale 1ns/10ps
`default_nettype none
module fp_mac_pipeline_unit (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst_b,
	// code word and flow control
	input  wire logic [fp_mac_pkg::CW-1:0] code_word,
	input  wire logic                  cancel_current_n,
	input  wire logic                  wait_state_n,
	// mode register load
	input  wire logic                  mode_load,
	input  wire logic [fp_mac_pkg::MODE_W-1:0] mode_value,
	// data port
	input  wire logic [31:0]           bidir_data_port_i,
	output logic      [31:0]           bidir_data_port_o,
	output logic                       bidir_data_port_oe,
	input  wire logic                  port_drive_enable_n,
	output logic                       port_out_valid,
	input  wire logic                  port_out_ready,
	output logic                       pipe_ready,
	// status
	output logic                       condition_flag_out,
	output logic                       exception_flag_out,
	output logic                       zero_flag_out
);
	// =====================================================
	// state
	typedef struct packed {
		logic        v;
		logic [2:0]  fn;
		logic        cvt;
		logic [4:0]  rc;
		logic        wreg;
		logic [1:0]  tdst;
		logic [1:0]  cn;
		logic        toport;
		logic        ovf;
		logic [31:0] x;
		logic [31:0] y;
	} stg_t;
	typedef struct packed {
		// RULE_06 thirty-two word file
		logic [31:0][31:0] rf;
		logic [2:0][31:0]  tmp;
		logic [33:0]       ir;
		logic              ir_v;
		stg_t              s1;
		stg_t              s2;
		logic [1:0][31:0]  ob;
		logic [1:0]        ob_cnt;
		logic              ob_hd;
		logic [1:0]        mode;
		logic              cond;
		logic              exc;
		logic              zero;
	} st_t;
	st_t q, d;
	logic [31:0] fall_q;

	// =====================================================
	// float helpers
	// RULE_04 single precision arithmetic
	function automatic logic [32:0] fmul(input logic [31:0] a, input logic [31:0] b);
		logic [47:0] p;
		logic [23:0] r;
		logic signed [10:0] e;
		logic s;
		s = a[31] ^ b[31];
		p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
		e = 11'($signed({3'h0, a[30:23]})) + 11'($signed({3'h0, b[30:23]}))
			- 11'($signed({3'h0, fp_mac_pkg::EXP_BIAS}));
		if (p[47]) begin
			r = {1'b0, p[46:24]} + {23'h0, p[23]};
			e = e + 11'sd1;
		end else begin
			r = {1'b0, p[45:23]} + {23'h0, p[22]};
		end
		if (r[23]) e = e + 11'sd1;
		if (a[30:23] == 8'h00 || b[30:23] == 8'h00 || e <= 11'sd0) fmul = {1'b0, s, 31'h0};
		else if (e >= 11'sd255) fmul = {1'b1, s, fp_mac_pkg::EXP_MAX, 23'h0};
		else fmul = {1'b0, s, e[7:0], r[22:0]};
	endfunction : fmul

	function automatic logic [32:0] fadd(input logic [31:0] a0, input logic [31:0] b0);
		logic [31:0] a, b;
		logic [26:0] mb;
		logic [27:0] s;
		logic [23:0] r;
		logic signed [10:0] e;
		logic [7:0] dd;
		logic done;
		if (a0[30:0] >= b0[30:0]) begin a = a0; b = b0; end
		else begin a = b0; b = a0; end
		dd = a[30:23] - b[30:23];
		mb = (dd > 8'd26) ? 27'h0 : ({1'b1, b[22:0], 3'h0} >> dd);
		e = 11'($signed({3'h0, a[30:23]}));
		s = (a[31] ^ b[31]) ? {1'b0, a[22:0] == 23'h0 ? 27'h4000000 : {1'b1, a[22:0], 3'h0}} - {1'b0, mb}
			: {2'b01, a[22:0], 3'h0} + {1'b0, mb};
		done = 1'b0;
		if (s[27]) begin
			s = s >> 1;
			e = e + 11'sd1;
		end
		for (int i = 0; i < 27; i++) begin
			if (!done && !s[26] && s != 28'h0) begin
				s = s << 1;
				e = e - 11'sd1;
			end else done = 1'b1;
		end
		r = {1'b0, s[25:3]} + {23'h0, s[2]};
		if (r[23]) e = e + 11'sd1;
		if (b[30:23] == 8'h00) fadd = {1'b0, a};
		else if (s == 28'h0 || e <= 11'sd0) fadd = 33'h0;
		else if (e >= 11'sd255) fadd = {1'b1, a[31], fp_mac_pkg::EXP_MAX, 23'h0};
		else fadd = {1'b0, a[31], e[7:0], r[22:0]};
	endfunction : fadd

	// float to integer; top bit flags a range error
	function automatic logic [32:0] ffix(input logic [31:0] a);
		logic [9:0] e;
		logic [31:0] v;
		e = {2'h0, a[30:23]};
		v = (e >= fp_mac_pkg::FIX_BASE) ? ({8'h0, 1'b1, a[22:0]} << (e - fp_mac_pkg::FIX_BASE))
			: ({8'h0, 1'b1, a[22:0]} >> (fp_mac_pkg::FIX_BASE - e));
		if (e < {2'h0, fp_mac_pkg::EXP_BIAS}) ffix = 33'h0;
		else if (e > fp_mac_pkg::FIX_LIM) ffix = {1'b1, a[31] ? fp_mac_pkg::INT_MAXN : fp_mac_pkg::INT_MAXP};
		else ffix = {1'b0, a[31] ? -v : v};
	endfunction : ffix

	// integer to float, truncating low bits
	function automatic logic [31:0] fflt(input logic [31:0] a);
		logic [31:0] m;
		logic [7:0] p;
		m = a[31] ? -a : a;
		p = 8'h0;
		for (int i = 0; i < 32; i++) begin
			if (m[i]) p = 8'(i);
		end
		m = m << (8'd31 - p);
		fflt = (a == 32'h0) ? 32'h0 : {a[31], fp_mac_pkg::EXP_BIAS + p, m[30:8]};
	endfunction : fflt

	// =====================================================
	// next state
	logic        issue, push_st, push_rs, freeze;
	logic [1:0]  npush, wr_i;
	logic [31:0] opa, opb, acc, res, ld_data;
	logic [32:0] mr, sr, fx;
	stg_t        s1n;
	always_comb begin
		d = q;
		s1n = '0;
		res = '0;
		fx = '0;
		wr_i = '0;
		// RULE_22 cancel voids issue
		issue = q.ir_v & cancel_current_n;
		// RULE_17 port transfer decode
		push_st = issue && q.ir[fp_mac_pkg::C_IO +: 2] == fp_mac_pkg::IO_STORE;
		push_rs = q.s2.v && q.s2.toport;
		npush = {1'b0, push_st} + {1'b0, push_rs};
		// three bits so that a full buffer plus two pushes cannot wrap
		freeze = ({1'b0, npush} + {1'b0, q.ob_cnt}) > 3'(fp_mac_pkg::OBUF_N);
		// RULE_15 register address fields
		// RULE_07 two operand reads
		opa = q.ir[fp_mac_pkg::C_ASRC] ? bidir_data_port_i : q.rf[q.ir[fp_mac_pkg::C_RA +: 5]];
		opb = q.rf[q.ir[fp_mac_pkg::C_RB +: 5]];
		// RULE_10 temporary as addend
		acc = (q.ir[fp_mac_pkg::C_TSRC +: 2] == fp_mac_pkg::TMP_NONE) ? 32'h0
			: q.tmp[q.ir[fp_mac_pkg::C_TSRC +: 2]];
		// RULE_19 falling sample in double pump
		ld_data = q.mode[fp_mac_pkg::M_DPUMP] ? fall_q : bidir_data_port_i;
		mr = fmul(opa, opb);
		sr = fadd(q.s1.x, q.s1.y);
		// output buffer drain
		if (q.ob_cnt != 2'h0 && port_out_ready) begin
			d.ob_cnt = q.ob_cnt - 2'h1;
			d.ob_hd = ~q.ob_hd;
		end
		if (!freeze) begin
			// RULE_13 latch code word, RULE_23 stall voids it
			d.ir = code_word;
			d.ir_v = wait_state_n;
			// RULE_16 function and routing fields
			s1n.v = issue && q.ir[fp_mac_pkg::C_FN +: 3] != fp_mac_pkg::FN_NOP;
			s1n.fn = q.ir[fp_mac_pkg::C_FN +: 3];
			s1n.cvt = q.ir[fp_mac_pkg::C_CVT];
			s1n.rc = q.ir[fp_mac_pkg::C_RC +: 5];
			s1n.wreg = q.ir[fp_mac_pkg::C_WREG];
			s1n.tdst = q.ir[fp_mac_pkg::C_TDST +: 2];
			s1n.cn = q.ir[fp_mac_pkg::C_CN +: 2];
			s1n.toport = q.ir[fp_mac_pkg::C_IO +: 2] == fp_mac_pkg::IO_RESULT;
			s1n.x = opa;
			s1n.y = 32'h0;
			// RULE_03 multiply in first stage
			unique case (fp_mac_pkg::fn_t'(s1n.fn))
				fp_mac_pkg::FN_MUL: {s1n.ovf, s1n.x} = mr;
				fp_mac_pkg::FN_ADD: s1n.y = opb;
				fp_mac_pkg::FN_SUB: s1n.y = {~opb[31], opb[30:0]};
				fp_mac_pkg::FN_MAC: begin
					{s1n.ovf, s1n.x} = mr;
					s1n.y = acc;
				end
				fp_mac_pkg::FN_MSB: begin
					{s1n.ovf, s1n.x} = {mr[32], ~mr[31], mr[30:0]};
					s1n.y = acc;
				end
				// RULE_12 seed feeds divide steps
				// RULE_11 reciprocal seed lookup
				fp_mac_pkg::FN_RCP: begin
					s1n.x = {opa[31], fp_mac_pkg::RCP_K - opa[30:23], ~opa[22:0]};
					s1n.ovf = opa[30:23] == 8'h00;
				end
				default: s1n.x = opa;
			endcase
			// RULE_02 stages advance each cycle
			d.s1 = s1n;
			d.s2 = q.s1;
			// RULE_03 add or subtract in second stage
			if (q.s1.fn != fp_mac_pkg::FN_CVT) begin
				d.s2.x = sr[31:0];
				d.s2.ovf = q.s1.ovf | sr[32];
			end
			// RULE_05 convert in last stage
			res = q.s2.x;
			if (q.s2.fn == fp_mac_pkg::FN_CVT) begin
				fx = ffix(q.s2.x);
				res = q.s2.cvt ? fx[31:0] : fflt(q.s2.x);
			end
			// RULE_01 writeback three cycles after issue
			if (q.s2.v && q.s2.wreg) d.rf[q.s2.rc] = res;
			if (q.s2.v && q.s2.tdst != fp_mac_pkg::TMP_NONE) d.tmp[q.s2.tdst] = res;
			// RULE_09 port load into register file
			if (issue && q.ir[fp_mac_pkg::C_IO +: 2] == fp_mac_pkg::IO_LOAD) begin
				d.rf[q.ir[fp_mac_pkg::C_RD +: 5]] = ld_data;
			end
			// RULE_14 flags at writeback
			if (q.s2.v && q.s2.cn != fp_mac_pkg::CN_NONE) begin
				// RULE_25 exact zero
				d.zero = res[30:0] == 31'h0;
				unique case (fp_mac_pkg::cond_t'(q.s2.cn))
					fp_mac_pkg::CN_ZERO: d.cond = res[30:0] == 31'h0;
					fp_mac_pkg::CN_NEG:  d.cond = res[31] && res[30:0] != 31'h0;
					default:             d.cond = !res[31] && res[30:0] != 31'h0;
				endcase
			end
			if (q.s2.v) begin
				d.exc = q.s2.ovf | (fx[32] & q.mode[fp_mac_pkg::M_RANGE]);
			end
			// RULE_08 up to two words per cycle into buffer
			wr_i = {1'b0, q.ob_hd} + q.ob_cnt; // tail stays put when the head pops
			if (push_st) begin
				d.ob[wr_i[0]] = q.rf[q.ir[fp_mac_pkg::C_RD +: 5]];
				wr_i = wr_i + 2'h1;
			end
			if (push_rs) d.ob[wr_i[0]] = res;
			d.ob_cnt = d.ob_cnt + npush;
		end
		// RULE_18 mode register
		if (mode_load) d.mode = mode_value;
		if (!rst_b) begin
			d = '0;
			d.mode = fp_mac_pkg::MODE_RST;
		end
	end

	// =====================================================
	// registers
	always_ff @(posedge clk_sys) begin
		q <= d;
	end

	// falling edge capture for double pump loads
	always_ff @(negedge clk_sys) begin
		fall_q <= bidir_data_port_i;
	end

	// =====================================================
	// outputs
	assign bidir_data_port_o = q.ob[q.ob_hd];
	assign port_out_valid = q.ob_cnt != 2'h0;
	// RULE_20 drive gated by enable
	// RULE_24 release without the clock
	assign bidir_data_port_oe = port_out_valid & ~port_drive_enable_n;
	assign pipe_ready = ~freeze;
	// RULE_21 status to sequencer
	assign condition_flag_out = q.cond;
	assign exception_flag_out = q.exc;
	assign zero_flag_out = q.zero;
endmodule : fp_mac_pipeline_unit
`default_nettype wire

// File: testbench/fp_mac_props.sv
// checker of the float compute unit port relations
`timescale 1ns/10ps
`default_nettype none
module fp_mac_props (
	// clock and reset
	input wire logic                      clk_sys,
	input wire logic                      rst_b,
	// code path
	input wire logic [fp_mac_pkg::CW-1:0] code_word,
	input wire logic                      cancel_current_n,
	input wire logic                      wait_state_n,
	input wire logic                      pipe_ready,
	// data port
	input wire logic [31:0]               bidir_data_port_o,
	input wire logic                      bidir_data_port_oe,
	input wire logic                      port_drive_enable_n,
	input wire logic                      port_out_valid,
	input wire logic                      port_out_ready,
	// status
	input wire logic                      condition_flag_out,
	input wire logic                      exception_flag_out,
	input wire logic                      zero_flag_out
);
	// code word fields
	wire logic [1:0] io_w = code_word[fp_mac_pkg::C_IO+:2];
	wire logic [1:0] cn_w = code_word[fp_mac_pkg::C_CN+:2];
	wire logic [2:0] fn_w = code_word[fp_mac_pkg::C_FN+:3];
	// =====================================================
	// port relations
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// store taken and not voided
	sequence s_store;
		pipe_ready && wait_state_n && io_w == 2'h2 ##1 cancel_current_n && pipe_ready;
	endsequence
	a_drive_gate: assert property (
		bidir_data_port_oe == (port_out_valid && !port_drive_enable_n))
		else $error("port drive enable wrong");
	a_word_stands: assert property (
		port_out_valid && !port_out_ready |=> port_out_valid && $stable(bidir_data_port_o))
		else $error("port word lost while stalled");
	a_reset_clear: assert property (disable iff (1'b0) !rst_b |=>
		!port_out_valid && !condition_flag_out && !exception_flag_out && !zero_flag_out
		&& pipe_ready) else $error("outputs not cleared by reset");
	a_store_out: assert property (s_store |=> port_out_valid)
		else $error("store word not offered");
	a_freeze_full: assert property (!pipe_ready |-> port_out_valid)
		else $error("frozen with empty buffer");
	a_zero_cause: assert property ($rose(zero_flag_out) |-> $past(cn_w, 4) != 2'h0)
		else $error("zero flag without condition field");
	a_exc_cause: assert property ($rose(exception_flag_out) |-> $past(fn_w, 4) != 3'h0)
		else $error("exception without operation");
	a_valid_cause: assert property ($rose(port_out_valid) |->
		$past(io_w, 2) == 2'h2 || $past(io_w, 4) == 2'h3)
		else $error("port word without transfer");
endmodule : fp_mac_props
bind fp_mac_pipeline_unit fp_mac_props u_fp_mac_props (.clk_sys, .rst_b, .code_word,
	.cancel_current_n, .wait_state_n, .pipe_ready, .bidir_data_port_o, .bidir_data_port_oe,
	.port_drive_enable_n, .port_out_valid, .port_out_ready, .condition_flag_out,
	.exception_flag_out, .zero_flag_out);
`default_nettype wire

// File: testbench/fp_port_partner.sv
// far side model: takes port words and feeds load data
`timescale 1ns/10ps
`default_nettype none
module fp_port_partner (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// bench control
	input  wire logic        hold,
	input  wire logic        ld_en,
	input  wire logic [31:0] ld_val,
	// data port
	input  wire logic        port_out_valid,
	input  wire logic [31:0] bidir_data_port_o,
	input  wire logic        bidir_data_port_oe,
	output logic             port_out_ready,
	output logic [31:0]      bidir_data_port_i
);
	logic [31:0] rx_q [0:15];
	logic [31:0] last_q = 32'h0;
	int          n_rx;
	// one word per rising edge unless holding
	assign port_out_ready = !hold;
	// driven port word while enabled, else load word while ld_en is high, at both edges, else the inverse of the last level
	assign bidir_data_port_i = bidir_data_port_oe ? bidir_data_port_o : ld_en ? ld_val : ~last_q;
	// capture popped words
	always @(posedge clk_sys) begin
		last_q <= bidir_data_port_i;
		if (!rst_b)
			n_rx <= 0;
		else if (port_out_valid && port_out_ready) begin
			rx_q[n_rx[3:0]] <= bidir_data_port_o;
			n_rx <= n_rx + 1;
		end
	end
endmodule : fp_port_partner
`default_nettype wire

// File: testbench/tb_top.sv
// self checking bench of the float compute unit
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic                      clk_sys, rst_b, cancel_current_n, wait_state_n, hold, ld_en;
	logic [fp_mac_pkg::CW-1:0] code_word;
	logic                      mode_load;
	logic [1:0]                mode_value;
	logic [31:0]               ld_val, bidir_data_port_i, bidir_data_port_o;
	logic                      port_drive_enable_n, bidir_data_port_oe, port_out_valid;
	logic                      port_out_ready, pipe_ready, condition_flag_out;
	logic                      exception_flag_out, zero_flag_out;
	int                        n_fail, n_checks, rx_k;
	localparam logic [33:0]    NOPW = {1'b1, 4'hf, 29'h0};
	// =====================================================
	// design and far side
	fp_mac_pipeline_unit u_fp_mac_pipeline_unit (.clk_sys, .rst_b, .code_word, .cancel_current_n,
		.wait_state_n, .mode_load, .mode_value, .bidir_data_port_i,
		.bidir_data_port_o, .bidir_data_port_oe, .port_drive_enable_n, .port_out_valid,
		.port_out_ready, .pipe_ready, .condition_flag_out, .exception_flag_out, .zero_flag_out);
	fp_port_partner u_fp_port_partner (.clk_sys, .rst_b, .hold, .ld_en, .ld_val, .port_out_valid,
		.bidir_data_port_o, .bidir_data_port_oe, .port_out_ready, .bidir_data_port_i);
	// clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// =====================================================
	// helpers
	task automatic tally_and_finish;
		if (n_fail == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [33:0] mk(input logic [2:0] f, input logic [4:0] a, b, c, d,
		input logic [1:0] io, cn, ts, td);
		return {1'b1, td, ts, f != 3'h0, 1'b0, cn, io, f, d, c, b, a};
	endfunction : mk
	// present one code word with load data and cancel for the previous one
	task automatic issue(input logic [33:0] cw, input logic le, input logic [31:0] lv,
		input logic cn);
		int i;
		code_word = cw;
		ld_en = le;
		ld_val = lv;
		cancel_current_n = cn;
		#1;
		for (i = 0; pipe_ready !== 1'b1; i++) begin
			if (i == 20) begin
				n_fail++;
				tally_and_finish();
			end
			@(negedge clk_sys);
			#1;
		end
		@(negedge clk_sys);
	endtask : issue
	task automatic nops(input int n);
		repeat (n) issue(NOPW, 1'b0, 32'h0, 1'b1);
	endtask : nops
	task automatic st(input logic [4:0] r);
		issue(mk(3'h0, 0, 0, 0, r, 2'h2, 0, 3, 3), 1'b0, 32'h0, 1'b1);
	endtask : st
	task automatic exp_rx(input logic [31:0] e);
		int i;
		for (i = 0; u_fp_port_partner.n_rx <= rx_k; i++) begin
			if (i == 20) begin
				n_fail++;
				tally_and_finish();
			end
			@(negedge clk_sys);
		end
		chk(u_fp_port_partner.rx_q[rx_k], e);
		rx_k++;
	endtask : exp_rx
	// =====================================================
	// scenarios
	task automatic t_arith;
		issue(mk(3'h0, 0, 0, 0, 1, 2'h1, 0, 3, 3), 1'b0, 32'h0, 1'b1);
		issue(mk(3'h0, 0, 0, 0, 2, 2'h1, 0, 3, 3), 1'b1, 32'h3f800000, 1'b1);
		issue(mk(fp_mac_pkg::FN_MUL, 1, 2, 3, 0, 0, 0, 3, 3), 1'b1, 32'h40000000, 1'b1);
		issue(mk(fp_mac_pkg::FN_ADD, 1, 2, 4, 0, 0, 0, 3, 3), 1'b0, 32'h0, 1'b1);
		issue(mk(fp_mac_pkg::FN_SUB, 1, 1, 5, 0, 0, 1, 3, 3), 1'b0, 32'h0, 1'b1);
		nops(3);
		chk({31'h0, zero_flag_out}, 32'h1);
		chk({31'h0, condition_flag_out}, 32'h1);
		st(3);
		st(4);
		nops(2);
		exp_rx(32'h40000000);
		exp_rx(32'h40400000);
	endtask : t_arith
	task automatic t_void;
		issue(mk(fp_mac_pkg::FN_MUL, 1, 2, 7, 0, 0, 0, 3, 3), 1'b0, 32'h0, 1'b1);
		issue(NOPW, 1'b0, 32'h0, 1'b0);
		wait_state_n = 1'b0;
		issue(mk(fp_mac_pkg::FN_MUL, 1, 2, 8, 0, 0, 0, 3, 3), 1'b0, 32'h0, 1'b1);
		wait_state_n = 1'b1;
		nops(3);
		st(7);
		st(8);
		nops(2);
		exp_rx(32'h0);
		exp_rx(32'h0);
	endtask : t_void
	task automatic t_buffer;
		hold = 1'b1;
		st(3);
		st(4);
		st(5);
		code_word = NOPW;
		#1 chk({31'h0, pipe_ready}, 32'h0);
		port_drive_enable_n = 1'b1;
		#1 chk({31'h0, bidir_data_port_oe}, 32'h0);
		port_drive_enable_n = 1'b0;
		#1 chk({31'h0, bidir_data_port_oe}, 32'h1);
		hold = 1'b0;
		nops(3);
		exp_rx(32'h40000000);
		exp_rx(32'h40400000);
		exp_rx(32'h0);
	endtask : t_buffer
	task automatic t_temp;
		issue(mk(fp_mac_pkg::FN_MUL, 1, 2, 9, 0, 0, 0, 3, 0), 1'b0, 32'h0, 1'b1);
		nops(3);
		issue(mk(fp_mac_pkg::FN_MAC, 1, 2, 10, 0, 0, 0, 0, 3), 1'b0, 32'h0, 1'b1);
		issue(mk(fp_mac_pkg::FN_ADD, 1, 2, 14, 0, 2'h3, 0, 3, 3), 1'b0, 32'h0, 1'b1);
		issue(mk(fp_mac_pkg::FN_RCP, 2, 0, 11, 0, 0, 0, 3, 3), 1'b0, 32'h0, 1'b1);
		issue(mk(fp_mac_pkg::FN_CVT, 2, 0, 12, 0, 0, 0, 3, 3), 1'b0, 32'h0, 1'b1);
		issue(mk(fp_mac_pkg::FN_RCP, 0, 0, 13, 0, 0, 0, 3, 3), 1'b0, 32'h0, 1'b1);
		nops(3);
		chk({31'h0, exception_flag_out}, 32'h1);
		st(10);
		st(11);
		st(12);
		nops(2);
		exp_rx(32'h40400000);
		exp_rx(32'h40800000);
		exp_rx(32'h3effffff);
		exp_rx(32'h00000002);
	endtask : t_temp
	// double pump loads, range test off, int to float, sign conditions
	task automatic t_mode;
		mode_value = 2'h1;
		mode_load = 1'b1;
		@(negedge clk_sys);
		mode_load = 1'b0;
		issue(mk(3'h0, 0, 0, 0, 20, 2'h1, 0, 3, 3), 1'b1, 32'h4f800000, 1'b1);
		issue(NOPW, 1'b1, 32'h4f800000, 1'b1);
		issue(mk(3'h0, 0, 0, 0, 22, 2'h1, 0, 3, 3), 1'b1, 32'h2, 1'b1);
		issue(mk(fp_mac_pkg::FN_CVT, 20, 0, 21, 0, 0, 0, 3, 3), 1'b1, 32'h2, 1'b1);
		issue(mk(fp_mac_pkg::FN_CVT, 22, 0, 25, 0, 0, 0, 3, 3) ^ {1'b1, 33'h0}, 1'b0, 32'h0, 1'b1);
		nops(2);
		chk({31'h0, exception_flag_out}, 32'h0);
		issue(mk(fp_mac_pkg::FN_SUB, 5, 1, 23, 0, 0, 2'h3, 3, 3), 1'b0, 32'h0, 1'b1);
		nops(3);
		chk({30'h0, condition_flag_out, zero_flag_out}, 32'h0);
		issue(mk(fp_mac_pkg::FN_SUB, 5, 1, 24, 0, 0, 2'h2, 3, 3), 1'b0, 32'h0, 1'b1);
		nops(3);
		chk({31'h0, condition_flag_out}, 32'h1);
		st(20);
		st(21);
		st(25);
		nops(2);
		exp_rx(32'h4f800000);
		exp_rx(32'h7fffffff);
		exp_rx(32'h40000000);
	endtask : t_mode
	// =====================================================
	// main sequence
	initial begin
		n_fail = 0;
		n_checks = 0;
		rx_k = 0;
		rst_b = 1'b0;
		code_word = NOPW;
		cancel_current_n = 1'b1;
		wait_state_n = 1'b1;
		port_drive_enable_n = 1'b0;
		hold = 1'b0;
		ld_en = 1'b0;
		ld_val = 32'h0;
		mode_load = 1'b0;
		mode_value = 2'h2;
		repeat (5) @(negedge clk_sys);
		rst_b = 1'b1;
		@(negedge clk_sys);
		t_arith();
		t_void();
		t_buffer();
		t_temp();
		t_mode();
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
